// ---- hdl/bstap_defines.vh ----
/*
  Constants for the boundary-scan test access port: controller states,
  instruction codes, register widths and reset values.
  Assumes inclusion by bare name from the design files of this block.
*/
// Operation
// - Sample on test clock rise, drive on fall
// - Mode select and data in pulled high
// - Data in enters selected register MSB
// - Data out leaves selected register LSB
// - Five high mode-select edges reset controller
// - Controller reset leaves memory operation alone
// - Power-up resets controller, data out floats
// - One register in path, chosen by instruction
// - Three-bit instruction register, serially loaded
// - Reset loads identification instruction
// - Instruction capture loads binary 01 low
// - One-bit bypass, cleared under bypass instruction
// - Boundary captures pin ring, then shifts
// - Boundary includes spare unconnected cells
// - Extest, sample-preload, sample-float select boundary
// - Identification captures 32-bit code
// - Identification constant shifted out in shift
// - Data out driven only in some states
// - Full standard state sequence by mode select
// - Instruction takes effect at instruction update
`ifndef BSTAP_DEFINES_VH
`define BSTAP_DEFINES_VH

// Controller states
`define BSTAP_ST_RESET   4'h0
`define BSTAP_ST_IDLE    4'h1
`define BSTAP_ST_SEL_DR  4'h2
`define BSTAP_ST_CAP_DR  4'h3
`define BSTAP_ST_SH_DR   4'h4
`define BSTAP_ST_EX1_DR  4'h5
`define BSTAP_ST_PA_DR   4'h6
`define BSTAP_ST_EX2_DR  4'h7
`define BSTAP_ST_UP_DR   4'h8
`define BSTAP_ST_SEL_IR  4'h9
`define BSTAP_ST_CAP_IR  4'hA
`define BSTAP_ST_SH_IR   4'hB
`define BSTAP_ST_EX1_IR  4'hC
`define BSTAP_ST_PA_IR   4'hD
`define BSTAP_ST_EX2_IR  4'hE
`define BSTAP_ST_UP_IR   4'hF

// Instruction codes
`define BSTAP_IR_W        3
`define BSTAP_I_EXTEST    3'h0
`define BSTAP_I_IDCODE    3'h1
`define BSTAP_I_SAMPLEZ   3'h2
`define BSTAP_I_SAMPLE    3'h4
`define BSTAP_I_BYPASS    3'h7
`define BSTAP_IR_CAPTURE  3'h1

// Register widths and defaults
`define BSTAP_ID_W        32
`define BSTAP_ID_DEFAULT  32'h0000_0001
`define BSTAP_BSR_W       16
`define BSTAP_BSR_SPARE   4
`define BSTAP_PIN_W       12
`define BSTAP_SYNC_W      2
`define BSTAP_PIN_N       3
`define BSTAP_PIN_RST     3'h3

`endif

// ---- hdl/bstap_sync.v ----
/*
  Two-flop synchroniser for a bus of asynchronous inputs.
  Assumes clk_i is the block clock; inputs come from pins.
*/
`timescale 1ns/100ps
module bstap_sync #(
  parameter             WIDTH   = 3,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage read only by second
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= RST_VAL;  // Idle pin levels, no false edge
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule // bstap_sync

// ---- hdl/bstap_tap.v ----
/*
  Boundary-scan test access port: state controller, instruction,
  bypass, identification and boundary registers, serial data out.
  Assumes test clock, mode select and data in arrive from pins,
  asynchronous to clk_i, slow enough to be oversampled.
  Test clock must stay at least three block clocks high and low;
  mode select and data in must hold across the sampled rise.
  Outputs feed the memory's pin logic and the data-out pad.
*/
`timescale 1ns/100ps
`include "bstap_defines.vh"
module bstap_tap #(
  parameter                   PIN_W   = `BSTAP_PIN_W,
  parameter                   SPARE_W = `BSTAP_BSR_SPARE,
  parameter [`BSTAP_ID_W-1:0] ID_CODE = `BSTAP_ID_DEFAULT  // Arbitrary value
) (
  input  wire             clk_i,
  input  wire             rst_b_i,
  input  wire             tck_i,
  input  wire             tms_i,
  input  wire             tdi_i,
  input  wire [PIN_W-1:0] pin_ring_i,
  output reg              tdo_o,
  output reg              tdo_oe_o,
  output reg  [PIN_W-1:0] pin_drive_o,
  output reg              out_float_o,
  output reg              extest_o
);
  localparam BSR_W = PIN_W + SPARE_W + 1;

  wire       tck_s;
  wire       tms_s;
  wire       tdi_s;
  reg        tck_d_reg;
  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  reg  [`BSTAP_IR_W-1:0] ir_sh_reg;
  reg  [`BSTAP_IR_W-1:0] ir_reg;
  reg        byp_reg;
  reg  [`BSTAP_ID_W-1:0] id_reg;
  reg  [BSR_W-1:0] bsr_reg;
  reg  [BSR_W-1:0] bsr_upd_reg;
  reg        tdo_next;
  reg        tdo_oe_next;
  reg  [PIN_W-1:0] pin_drive_next;
  reg        out_float_next;
  reg        extest_next;

  // Pin synchronisers, pull-ups modelled as reset high
  bstap_sync #(.WIDTH(`BSTAP_PIN_N), .RST_VAL(`BSTAP_PIN_RST)) u_sync (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       ({tck_i, tms_i, tdi_i}),
    .q_o       ({tck_s, tms_s, tdi_s})
  );

  wire tck_rise = tck_s & ~tck_d_reg;
  wire tck_fall = ~tck_s & tck_d_reg;

  // Boundary selected by any of the three ring instructions
  function sel_bsr;
    input [`BSTAP_IR_W-1:0] ins;
    begin
      sel_bsr = (ins == `BSTAP_I_EXTEST) || (ins == `BSTAP_I_SAMPLE) ||
                (ins == `BSTAP_I_SAMPLEZ);
    end
  endfunction

  // Instruction decodes shared by data paths and outputs
  wire id_sel     = (ir_reg == `BSTAP_I_IDCODE);
  wire bsr_sel    = sel_bsr(ir_reg);
  wire extest_sel = (ir_reg == `BSTAP_I_EXTEST);

  // Controller next state from mode select
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `BSTAP_ST_RESET: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_RESET;
        end else begin
          state_next = `BSTAP_ST_IDLE;
        end
      end
      `BSTAP_ST_IDLE: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_SEL_DR;
        end else begin
          state_next = `BSTAP_ST_IDLE;
        end
      end
      `BSTAP_ST_SEL_DR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_SEL_IR;
        end else begin
          state_next = `BSTAP_ST_CAP_DR;
        end
      end
      `BSTAP_ST_CAP_DR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_EX1_DR;
        end else begin
          state_next = `BSTAP_ST_SH_DR;
        end
      end
      `BSTAP_ST_SH_DR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_EX1_DR;
        end else begin
          state_next = `BSTAP_ST_SH_DR;
        end
      end
      `BSTAP_ST_EX1_DR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_UP_DR;
        end else begin
          state_next = `BSTAP_ST_PA_DR;
        end
      end
      `BSTAP_ST_PA_DR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_EX2_DR;
        end else begin
          state_next = `BSTAP_ST_PA_DR;
        end
      end
      `BSTAP_ST_EX2_DR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_UP_DR;
        end else begin
          state_next = `BSTAP_ST_SH_DR;
        end
      end
      `BSTAP_ST_UP_DR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_SEL_DR;
        end else begin
          state_next = `BSTAP_ST_IDLE;
        end
      end
      `BSTAP_ST_SEL_IR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_RESET;
        end else begin
          state_next = `BSTAP_ST_CAP_IR;
        end
      end
      `BSTAP_ST_CAP_IR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_EX1_IR;
        end else begin
          state_next = `BSTAP_ST_SH_IR;
        end
      end
      `BSTAP_ST_SH_IR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_EX1_IR;
        end else begin
          state_next = `BSTAP_ST_SH_IR;
        end
      end
      `BSTAP_ST_EX1_IR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_UP_IR;
        end else begin
          state_next = `BSTAP_ST_PA_IR;
        end
      end
      `BSTAP_ST_PA_IR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_EX2_IR;
        end else begin
          state_next = `BSTAP_ST_PA_IR;
        end
      end
      `BSTAP_ST_EX2_IR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_UP_IR;
        end else begin
          state_next = `BSTAP_ST_SH_IR;
        end
      end
      `BSTAP_ST_UP_IR: begin
        if (tms_s) begin
          state_next = `BSTAP_ST_SEL_DR;
        end else begin
          state_next = `BSTAP_ST_IDLE;
        end
      end
      default:          state_next = `BSTAP_ST_RESET;
    endcase
  end

  // Edge detect and controller state; power-up reset
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tck_d_reg <= 1'b0;
      state_reg <= `BSTAP_ST_RESET;
    end else begin
      tck_d_reg <= tck_s;
      if (tck_rise) begin
        state_reg <= state_next;
      end
    end
  end

  // Instruction path: capture, shift, update
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ir_sh_reg <= `BSTAP_I_IDCODE;
      ir_reg    <= `BSTAP_I_IDCODE;
    end else if (tck_rise) begin
      case (state_reg)
        `BSTAP_ST_RESET:  ir_reg <= `BSTAP_I_IDCODE;
        `BSTAP_ST_CAP_IR: ir_sh_reg <= `BSTAP_IR_CAPTURE;
        `BSTAP_ST_SH_IR:  ir_sh_reg <= {tdi_s, ir_sh_reg[`BSTAP_IR_W-1:1]};
        `BSTAP_ST_UP_IR:  ir_reg <= ir_sh_reg;
        default:          ir_reg <= ir_reg;
      endcase
    end
  end

  // Bypass: cleared at capture, shifts in shift
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byp_reg <= 1'b0;
    end else if (tck_rise) begin
      if (state_reg == `BSTAP_ST_CAP_DR) begin
        byp_reg <= 1'b0;
      end else if (state_reg == `BSTAP_ST_SH_DR) begin
        byp_reg <= tdi_s;
      end
    end
  end

  // Identification: fixed code captured, then shifted
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      id_reg <= {`BSTAP_ID_W{1'b0}};
    end else if (tck_rise && id_sel) begin
      if (state_reg == `BSTAP_ST_CAP_DR) begin
        id_reg <= ID_CODE;
      end else if (state_reg == `BSTAP_ST_SH_DR) begin
        id_reg <= {tdi_s, id_reg[`BSTAP_ID_W-1:1]};
      end
    end
  end

  // Boundary shift stage: pin ring capture, spares read zero
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bsr_reg <= {BSR_W{1'b0}};
    end else if (tck_rise && bsr_sel) begin
      if (state_reg == `BSTAP_ST_CAP_DR) begin
        bsr_reg <= {bsr_reg[BSR_W-1], {SPARE_W{1'b0}}, pin_ring_i};
      end else if (state_reg == `BSTAP_ST_SH_DR) begin
        bsr_reg <= {tdi_s, bsr_reg[BSR_W-1:1]};
      end
    end
  end

  // Boundary update latch; output-enable cell preset high
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bsr_upd_reg <= {1'b1, {(BSR_W-1){1'b0}}};
    end else if (tck_rise) begin
      if (state_reg == `BSTAP_ST_RESET) begin
        bsr_upd_reg[BSR_W-1] <= 1'b1;
      end else if (state_reg == `BSTAP_ST_UP_DR && bsr_sel) begin
        bsr_upd_reg <= bsr_reg;
      end
    end
  end

  // Serial out selects one register's LSB
  always @* begin
    tdo_next = byp_reg;
    if (state_reg == `BSTAP_ST_SH_IR) begin
      tdo_next = ir_sh_reg[0];
    end else if (ir_reg == `BSTAP_I_IDCODE) begin
      tdo_next = id_reg[0];
    end else if (sel_bsr(ir_reg)) begin
      tdo_next = bsr_reg[0];
    end
  end

  // Next values of the pin-facing outputs
  always @* begin
    tdo_oe_next    = (state_reg == `BSTAP_ST_SH_DR) || (state_reg == `BSTAP_ST_SH_IR);
    pin_drive_next = bsr_upd_reg[PIN_W-1:0];
    out_float_next = (ir_reg == `BSTAP_I_SAMPLEZ) || (extest_sel && !bsr_upd_reg[BSR_W-1]);
    extest_next    = extest_sel;
  end

  // Outputs change on the falling test-clock edge
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tdo_o       <= 1'b0;
      tdo_oe_o    <= 1'b0;
      pin_drive_o <= {PIN_W{1'b0}};
      out_float_o <= 1'b0;
      extest_o    <= 1'b0;
    end else if (tck_fall) begin
      tdo_o       <= tdo_next;
      tdo_oe_o    <= tdo_oe_next;
      pin_drive_o <= pin_drive_next;
      out_float_o <= out_float_next;
      extest_o    <= extest_next;
    end
  end
endmodule // bstap_tap

// ---- test/bstap_ctl_model.sv ----
/* Board scan controller model: walks the port states, shifts bits.
   Assumes a caller invokes one task at a time; clock parks low. */
`timescale 1ns/100ps
module bstap_ctl_model (
  input  wire tdo_i,
  output reg  tck_o,
  output reg  tms_o,
  output reg  tdi_o
);
  // Clock parked low, released lines float to pull-ups
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // One 64 ns clock, data out taken just before the rise
  task bit1(input m, input d, output o);
    begin
      tms_o = m;
      tdi_o = d;
      #32 o = tdo_i;
      tck_o = 1'b1;
      #32 tck_o = 1'b0;
    end
  endtask
  // Idle to shift, n bits LSB first, update, back to idle
  task scan(input ir, input [31:0] din, input integer n, output [31:0] dout);
    integer i;
    reg     o;
    begin
      dout = 32'h0;
      bit1(1'b1, 1'b1, o);
      if (ir)
        bit1(1'b1, 1'b1, o);
      bit1(1'b0, 1'b1, o);
      bit1(1'b0, 1'b1, o);
      for (i = 0; i < n; i = i + 1) begin
        bit1(i == n - 1, din[i], o);
        dout[i] = o;
      end
      bit1(1'b1, 1'b1, o);
      bit1(1'b0, 1'b1, o);
      tdi_o = 1'b1;
      tms_o = 1'b1;
      #32;  // Let the port see the last fall
    end
  endtask
  // Five high mode-select rises, then idle
  task rst5;
    integer i;
    reg     o;
    begin
      for (i = 0; i < 5; i = i + 1)
        bit1(1'b1, 1'b1, o);
      bit1(1'b0, 1'b1, o);
      tms_o = 1'b1;
      #32;  // Let the port see the last fall
    end
  endtask
endmodule // bstap_ctl_model

// ---- test/bstap_tap_chk.sv ----
/* Checker on the scan port pins and outputs.
   Assumes bind to bstap_tap; test clock far slower than clk_i. */
`timescale 1ns/100ps
module bstap_tap_chk #(
  parameter PIN_W = 12
) (
  input wire             clk_i,
  input wire             rst_b_i,
  input wire             tck_i,
  input wire             tms_i,
  input wire             tdi_i,
  input wire [PIN_W-1:0] pin_ring_i,
  input wire             tdo_o,
  input wire             tdo_oe_o,
  input wire [PIN_W-1:0] pin_drive_o,
  input wire             out_float_o,
  input wire             extest_o
);
  reg       tck_q;
  reg       tms_q;
  reg       fell_seen;
  reg [3:0] fall_age;
  reg [3:0] edge_age;
  reg [3:0] hi_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Ages since test clock edges, run of high mode-select rises
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tck_q     <= 1'b0;
      tms_q     <= 1'b1;
      fell_seen <= 1'b0;
      fall_age  <= 4'hF;
      edge_age  <= 4'hF;
      hi_cnt    <= 4'h5;
    end else begin
      tck_q    <= tck_i;
      fall_age <= (tck_q && !tck_i) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
      edge_age <= (tck_q != tck_i) ? 4'h0 : edge_age + {3'h0, edge_age != 4'hF};
      if (tck_q && !tck_i)
        fell_seen <= 1'b1;
      if (!tck_q && tck_i) begin
        tms_q  <= tms_i;
        hi_cnt <= tms_i ? hi_cnt + {3'h0, hi_cnt != 4'hF} : 4'h0;
      end
    end
  end
  AST_TDO_FALL: assert property (($changed(tdo_o) || $changed(tdo_oe_o)) |-> fall_age <= 4'h6)
    else $error("data out moved away from a test clock fall");
  AST_EXT_EDGE: assert property (($changed(extest_o) || $changed(out_float_o)) |-> edge_age <= 4'h6)
    else $error("mode output moved away from a test clock edge");
  AST_PWRUP: assert property (!fell_seen |-> !tdo_oe_o && !tdo_o && !extest_o && !out_float_o && pin_drive_o == 0)
    else $error("outputs left reset values before any clock");
  AST_OE_HOLD: assert property ($rose(tdo_oe_o) |=> tdo_oe_o [*8])
    else $error("data out drive too short");
  AST_OE_GAP: assert property ($fell(tdo_oe_o) |=> !tdo_oe_o [*8])
    else $error("data out drive resumed too soon");
  AST_OE_ENTER: assert property ($rose(tdo_oe_o) |-> !tms_q)
    else $error("shift entered without mode select low");
  AST_OE_LEAVE: assert property ($fell(tdo_oe_o) |-> tms_q)
    else $error("shift left without mode select high");
  AST_RST5: assert property (hi_cnt >= 4'h5 && fall_age == 4'h8 |-> !tdo_oe_o && !extest_o && !out_float_o)
    else $error("five high mode select rises did not reset");
  cover property ($rose(tdo_oe_o));
  cover property ($rose(extest_o));
  cover property ($rose(out_float_o));
endmodule // bstap_tap_chk

bind bstap_tap bstap_tap_chk #(.PIN_W(PIN_W)) chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .tck_i(tck_i),
  .tms_i(tms_i), .tdi_i(tdi_i), .pin_ring_i(pin_ring_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .pin_drive_o(pin_drive_o), .out_float_o(out_float_o), .extest_o(extest_o));

// ---- test/bstap_tap_test.sv ----
/* Self-checking bench for the scan port.
   Assumes the controller model drives the test pins. */
`timescale 1ns/100ps
`include "bstap_defines.vh"
module bstap_tap_test;
  localparam [31:0] ID = 32'hA5C30F69;  // Arbitrary value
  reg         clk_i = 1'b0;
  reg         rst_b_i = 1'b0;
  reg  [11:0] ring = 12'h000;
  wire        tck, tms, tdi, tdo, oe, flt, ext;
  wire [11:0] drv;
  wire        tdo_w = oe ? tdo : 1'bz;
  integer     failures = 0;
  integer     total_checks = 0;
  integer     cyc = 0;
  reg  [31:0] got;
  bstap_tap #(.ID_CODE(ID)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .pin_ring_i(ring), .tdo_o(tdo), .tdo_oe_o(oe), .pin_drive_o(drv), .out_float_o(flt), .extest_o(ext));
  bstap_ctl_model pm (.tdo_i(tdo_w), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task results;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] a);
    begin
      total_checks = total_checks + 1;
      if (e !== a) begin
        failures = failures + 1;
        $display("ERROR %s expected %h seen %h", nm, e, a);
      end
    end
  endtask
  task load_ir(input [2:0] c);
    begin
      pm.scan(1'b1, {29'h0, c}, 3, got);
      chk("ir_capture", 32'h1, {30'h0, got[1:0]});
    end
  endtask
  task t_pwrup;
    begin
      chk("pwrup_flags", 32'h0, {29'h0, oe, flt, ext});
      pm.rst5;
      pm.scan(1'b0, 32'h0, 32, got);
      chk("id_pwrup", ID, got);
    end
  endtask
  task t_bypass;
    integer k;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        load_ir(k ? 3'h3 : `BSTAP_I_BYPASS);
        pm.scan(1'b0, 32'hB4, 8, got);
        chk("bypass", 32'h68, got);
        chk("oe_idle", 32'h0, {31'h0, oe});
      end
    end
  endtask
  task t_bsr;
    integer k;
    begin
      @(negedge clk_i) ring = 12'h5A3;
      for (k = 0; k < 3; k = k + 1) begin
        load_ir(k == 0 ? `BSTAP_I_SAMPLE : (k == 1 ? `BSTAP_I_EXTEST : `BSTAP_I_SAMPLEZ));
        chk("ext_float", {30'h0, k == 1, k == 2}, {30'h0, ext, flt});
        pm.scan(1'b0, 32'h10C3C, 17, got);
        chk("boundary", 32'h05A3, {16'h0, got[15:0]});
      end
      load_ir(`BSTAP_I_EXTEST);
      pm.scan(1'b0, 32'h00C3C, 17, got);
      chk("extest_float", 32'h3, {30'h0, ext, flt});
      chk("pin_drive", 32'hC3C, {20'h0, drv});
    end
  endtask
  task t_rst;
    begin
      load_ir(`BSTAP_I_SAMPLEZ);
      pm.rst5;
      chk("float_rst", 32'h0, {31'h0, flt});
      pm.scan(1'b0, 32'h0, 32, got);
      chk("id_rst", ID, got);
    end
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      results;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i) rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_pwrup;
    t_bypass;
    t_bsr;
    t_rst;
    results;
  end
endmodule // bstap_tap_test
